// ---- rtl/lock_route_pkg.sv ----
// Types and constants shared by the lock and identifier-route checker.
// Assumes one partition with one upstream port and a core clock.
package lock_route_pkg;

  localparam int PORT_W = 4;
  localparam int DEF_NPORTS = 16;
  localparam logic [PORT_W-1:0] DEF_UP_PORT = 4'h0;
  localparam logic [PORT_W-1:0] LOCK_PORT_RESET = 4'h0;

  typedef enum logic [3:0] {
    K_CPL = 4'h0,
    K_CPL_LK = 4'h1,
    K_CPLD_LK = 4'h2,
    K_MSG_ID = 4'h3,
    K_MSG_T1 = 4'h4,
    K_MSG_T1_VD = 4'h5,
    K_MRDLK = 4'h6,
    K_MWR = 4'h7,
    K_UNLOCK = 4'h8,
    K_OTHER_P = 4'h9,
    K_OTHER_NP = 4'hA
  } tlp_kind_t;

  typedef enum logic [1:0] {
    V_FWD = 2'h0,
    V_DROP = 2'h1,
    V_UNEXP = 2'h2,
    V_UR = 2'h3
  } verdict_t;

  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_DSP = 3'b010,
    LK_BUS = 3'b100
  } lock_state_t;

  // Header facts already resolved by the ingress decoder
  typedef struct packed {
    tlp_kind_t kind;
    logic [PORT_W-1:0] src_port;
    logic [PORT_W-1:0] dst_port;
    logic route_ok;
    logic terminates_internal;
    logic dev_exists;
    logic targets_switch;
    logic is_vc0;
    logic inserted;
  } tlp_desc_t;

  typedef struct packed {
    verdict_t verdict;
    logic [PORT_W-1:0] egress;
    tlp_kind_t kind;
  } decision_t;

  localparam lock_state_t LOCK_RESET = LK_IDLE;

endpackage : lock_route_pkg

// ---- rtl/id_route_check.sv ----
// Stateless verdict for completions and identifier-routed messages.
// Assumes the descriptor is stable while valid; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module id_route_check (
  input wire lock_route_pkg::tlp_desc_t desc,
  input wire logic [lock_route_pkg::DEF_NPORTS-1:0] acs_uf_en,
  input wire logic [lock_route_pkg::PORT_W-1:0] up_port,
  output lock_route_pkg::verdict_t verdict,
  output logic [lock_route_pkg::PORT_W-1:0] egress
);
  import lock_route_pkg::*;

  logic loopback;
  logic uf_on;

  assign loopback = (desc.dst_port == desc.src_port);
  assign uf_on = acs_uf_en[desc.src_port];

  always_comb begin
    verdict = V_FWD;
    egress = desc.dst_port;
    case (desc.kind)
      K_CPL, K_CPL_LK, K_CPLD_LK: begin
        if (desc.terminates_internal) begin
          verdict = V_UNEXP;
        end else if (!desc.route_ok) begin
          verdict = V_DROP;
        end else if (loopback) begin
          if (uf_on) begin
            egress = up_port;
          end else begin
            verdict = V_DROP;
          end
        end
      end
      K_MSG_ID: begin
        if (!desc.route_ok || !desc.dev_exists) begin
          verdict = V_UR;
        end else if (loopback) begin
          if (uf_on) begin
            egress = up_port;
          end else begin
            verdict = V_UR;
          end
        end
      end
      K_MSG_T1: begin
        // Type 1 at switch port errors
        if (desc.targets_switch || desc.src_port == up_port) begin
          verdict = V_UR;
        end
      end
      K_MSG_T1_VD: verdict = V_DROP;
      default: verdict = V_FWD;
    endcase
  end

endmodule : id_route_check
`default_nettype wire

// ---- rtl/lock_route_ctrl.sv ----
// Partition lock controller with identifier-route verdicts.
// Operation
// - Loopback completion: drop, or upstream if forwarding
// - Drop completions lacking a valid route
// - Internally terminating completions are unexpected
// - Loopback ID message errors unless forwarding
// - Unroutable or missing-device ID messages error
// - Type 1 message at switch port errors
// - Vendor Type 1 messages discarded silently
// - One lock, upstream to one downstream
// - Locked-read locks target downstream port
// - Blocking affects only VC0 traffic
// - Posted traffic drains before locked read
// - Locked completion with data locks the upstream port
// - Posted upstream traffic drains before completion
// - Both locked means partition bus-locked
// - No config access while bus-locked; not blocked here, the controller only outputs bus_locked
// - Later locked reads keep lock state
// - Upstream memory writes pass, lock unchanged
// - Locked ports still insert own messages
// - Unlock frees partition, forwarded downstream
// - Posted drains first; unlocked ports ignore unlock
// - Blocked traffic held, never dropped
// - Request routing errors become unsupported requests
// Assumes the ingress side holds a descriptor until it is taken and
// reports, per egress port, whether posted requests are still queued.
`timescale 1ns/10ps
`default_nettype none
module lock_route_ctrl #(
  parameter int NPORTS = lock_route_pkg::DEF_NPORTS,
  parameter logic [lock_route_pkg::PORT_W-1:0] UP_PORT =
    lock_route_pkg::DEF_UP_PORT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire lock_route_pkg::tlp_desc_t in_desc,
  input wire logic [lock_route_pkg::DEF_NPORTS-1:0] acs_uf_en,
  input wire logic [lock_route_pkg::DEF_NPORTS-1:0] posted_to_port,
  input wire logic [lock_route_pkg::DEF_NPORTS-1:0] posted_dsp_to_up,
  input wire logic posted_from_up,
  output logic dec_valid,
  output lock_route_pkg::decision_t dec,
  output logic bus_locked,
  output logic dsp_locked,
  output logic up_locked,
  output logic [lock_route_pkg::PORT_W-1:0] locked_port
);
  import lock_route_pkg::*;

  typedef struct packed {
    lock_state_t st;
    logic [PORT_W-1:0] lock_port;
    logic dec_valid;
    decision_t dec;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;

  verdict_t rc_verdict;
  logic [PORT_W-1:0] rc_egress;
  verdict_t verdict;
  logic blocked;
  logic order_wait;
  logic in_fire;
  logic from_up;

  // True when egress is locked against this source
  function automatic logic lock_blocks(input ctrl_state_t cs,
                                       input logic [PORT_W-1:0] egr,
                                       input logic [PORT_W-1:0] src);
    logic r;
    r = 1'b0;
    if (cs.st != LK_IDLE && egr == cs.lock_port && src != UP_PORT) begin
      r = 1'b1;
    end
    if (cs.st == LK_BUS && egr == UP_PORT && src != cs.lock_port) begin
      r = 1'b1;
    end
    return r;
  endfunction : lock_blocks

  id_route_check u_check (
    .desc(in_desc),
    .acs_uf_en(acs_uf_en),
    .up_port(UP_PORT),
    .verdict(rc_verdict),
    .egress(rc_egress)
  );

  assign from_up = (in_desc.src_port == UP_PORT);

  // Lock sequencing can override the route verdict
  always_comb begin
    verdict = rc_verdict;
    case (in_desc.kind)
      K_MRDLK: begin
        if (!from_up || rc_egress == UP_PORT ||
            (s.st != LK_IDLE && rc_egress != s.lock_port)) begin
          verdict = V_UR;
        end
      end
      K_UNLOCK: begin
        if (!from_up || s.st == LK_IDLE) begin
          verdict = V_DROP;
        end
      end
      default: verdict = rc_verdict;
    endcase
  end

  assign blocked = in_desc.is_vc0 && !in_desc.inserted &&
                   lock_blocks(s, rc_egress, in_desc.src_port);

  always_comb begin
    order_wait = 1'b0;
    if (in_desc.kind == K_MRDLK && s.st == LK_IDLE) begin
      order_wait = posted_to_port[rc_egress];
    end
    if (in_desc.kind == K_CPLD_LK && s.st == LK_DSP &&
        in_desc.src_port == s.lock_port) begin
      order_wait = posted_dsp_to_up[s.lock_port];
    end
    if (in_desc.kind == K_UNLOCK && from_up && s.st != LK_IDLE) begin
      order_wait = posted_from_up;
    end
  end

  assign in_ready = (verdict != V_FWD) || !(blocked || order_wait);
  assign in_fire = in_valid && in_ready;

  always_comb begin
    next_s = s;
    next_s.dec_valid = in_fire;
    if (in_fire) begin
      next_s.dec.verdict = verdict;
      next_s.dec.egress = rc_egress;
      next_s.dec.kind = in_desc.kind;
      if (in_desc.kind == K_UNLOCK && verdict == V_FWD) begin
        next_s.dec.egress = s.lock_port;
      end
    end
    case (s.st)
      LK_IDLE: begin
        if (in_fire && in_desc.kind == K_MRDLK && verdict == V_FWD) begin
          next_s.st = LK_DSP;
          next_s.lock_port = rc_egress;
        end
      end
      LK_DSP: begin
        if (in_fire && in_desc.kind == K_CPLD_LK &&
            in_desc.src_port == s.lock_port && verdict == V_FWD) begin
          next_s.st = LK_BUS;
        end
        if (in_fire && in_desc.kind == K_UNLOCK && verdict == V_FWD) begin
          next_s.st = LK_IDLE;
        end
      end
      LK_BUS: begin
        if (in_fire && in_desc.kind == K_UNLOCK && verdict == V_FWD) begin
          next_s.st = LK_IDLE;
        end
      end
      default: next_s.st = LOCK_RESET;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s.st <= LOCK_RESET;
      s.lock_port <= LOCK_PORT_RESET;
      s.dec_valid <= 1'b0;
      s.dec <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dec_valid = s.dec_valid;
  assign dec = s.dec;
  // Status lets sideband gate config access
  assign bus_locked = (s.st == LK_BUS);
  assign dsp_locked = (s.st != LK_IDLE);
  assign up_locked = (s.st == LK_BUS);
  assign locked_port = s.lock_port;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic is_cpl;
  assign is_cpl = (in_desc.kind == K_CPL) || (in_desc.kind == K_CPL_LK) ||
                  (in_desc.kind == K_CPLD_LK);

  sequence s_take_mrdlk;
    in_fire && in_desc.kind == K_MRDLK && s.st == LK_IDLE &&
    verdict == V_FWD;
  endsequence

  sequence s_take_cpldlk;
    in_fire && in_desc.kind == K_CPLD_LK && s.st == LK_DSP &&
    in_desc.src_port == s.lock_port && verdict == V_FWD;
  endsequence

  sequence s_take_unlock;
    in_fire && in_desc.kind == K_UNLOCK && from_up && s.st != LK_IDLE;
  endsequence

  a_loop_cpl_drop: assert property (
    in_fire && is_cpl && !in_desc.terminates_internal && in_desc.route_ok &&
    in_desc.dst_port == in_desc.src_port && !acs_uf_en[in_desc.src_port]
    |=> dec_valid && dec.verdict == V_DROP)
    else $error("loopback completion not dropped");

  a_loop_cpl_up: assert property (
    in_fire && is_cpl && !in_desc.terminates_internal && in_desc.route_ok &&
    in_desc.dst_port == in_desc.src_port && acs_uf_en[in_desc.src_port]
    |=> dec.verdict == V_FWD && dec.egress == UP_PORT)
    else $error("loopback completion not sent upstream");

  a_noroute_drop: assert property (
    in_fire && is_cpl && !in_desc.terminates_internal && !in_desc.route_ok
    |=> dec.verdict == V_DROP)
    else $error("unroutable completion not dropped");

  a_unexp_cpl: assert property (
    in_fire && is_cpl && in_desc.terminates_internal
    |=> dec.verdict == V_UNEXP)
    else $error("internal completion not unexpected");

  a_msg_bad_route: assert property (
    in_fire && in_desc.kind == K_MSG_ID &&
    (!in_desc.route_ok || !in_desc.dev_exists)
    |=> dec.verdict == V_UR)
    else $error("bad message route not an error");

  a_t1_upstream: assert property (
    in_fire && in_desc.kind == K_MSG_T1 && from_up |=> dec.verdict == V_UR)
    else $error("upstream type 1 message not an error");

  a_vendor_drop: assert property (
    in_fire && in_desc.kind == K_MSG_T1_VD |=> dec.verdict == V_DROP)
    else $error("vendor type 1 message not discarded");

  a_lock_dsp: assert property (
    s_take_mrdlk |=> s.st == LK_DSP && s.lock_port == $past(rc_egress))
    else $error("locked read did not lock target");

  a_mrdlk_order: assert property (
    in_valid && in_desc.kind == K_MRDLK && s.st == LK_IDLE &&
    verdict == V_FWD && posted_to_port[rc_egress] |-> !in_ready)
    else $error("locked read passed queued posted");

  a_bus_lock: assert property (
    s_take_cpldlk |=> s.st == LK_BUS && bus_locked && up_locked)
    else $error("locked completion did not bus-lock");

  a_cpllk_keeps: assert property (
    s.st == LK_BUS && in_fire && in_desc.kind != K_UNLOCK |=> s.st == LK_BUS)
    else $error("bus lock left without unlock");

  a_unlock_frees: assert property (
    s_take_unlock |=> s.st == LK_IDLE && dec.egress == $past(s.lock_port))
    else $error("unlock did not free partition");

  a_block_hold: assert property (
    in_valid && verdict == V_FWD && blocked |-> !in_ready ##1 !dec_valid)
    else $error("blocked descriptor taken");

  a_loop_msg_err: assert property (
    in_fire && in_desc.kind == K_MSG_ID && in_desc.route_ok &&
    in_desc.dev_exists && in_desc.dst_port == in_desc.src_port &&
    !acs_uf_en[in_desc.src_port] |=> dec.verdict == V_UR)
    else $error("loopback message not an error");

  a_mrdlk_single: assert property (
    in_fire && in_desc.kind == K_MRDLK && s.st != LK_IDLE &&
    rc_egress != s.lock_port
    |=> dec.verdict == V_UR && s.lock_port == $past(s.lock_port))
    else $error("second lock sequence accepted");

  a_up_blocked: assert property (
    in_valid && s.st == LK_BUS && in_desc.is_vc0 && !in_desc.inserted &&
    verdict == V_FWD && rc_egress == UP_PORT &&
    in_desc.src_port != s.lock_port |-> !in_ready)
    else $error("traffic to locked upstream not held");

  a_insert_pass: assert property (
    in_valid && in_desc.inserted && verdict == V_FWD && !order_wait
    |-> in_ready)
    else $error("inserted message held by lock");

  a_unlock_ignored: assert property (
    in_fire && in_desc.kind == K_UNLOCK && (!from_up || s.st == LK_IDLE)
    |=> dec.verdict == V_DROP && s.st == $past(s.st))
    else $error("unlock at unlocked port acted on");

  a_reset_idle: assert property (
    $fell(rst) |-> s.st == LK_IDLE && !dec_valid)
    else $error("lock state not cleared by reset");

endmodule : lock_route_ctrl
`default_nettype wire

// ---- test/tlp_source.sv ----
// Far-side model: ingress ports offering decoded TLP descriptors.
// Assumes one offer at a time, started and ended on a falling edge.
`timescale 1ns/10ps
`default_nettype none
module tlp_source (
  input wire logic clk_sys,
  input wire logic in_ready,
  output logic in_valid,
  output lock_route_pkg::tlp_desc_t in_desc
);
  import lock_route_pkg::*;

  initial begin
    in_valid = 1'b0;
    in_desc = '0;
  end

  // Callers keep legal kinds
  // Ready is read after the falling edge, where it is settled until the
  // next rising edge; a withdrawn offer leaves after max_wait cycles.
  task automatic offer(input tlp_desc_t d, input int max_wait,
                       output logic taken);
    int n;
    taken = 1'b0;
    n = 0;
    @(negedge clk_sys);
    in_valid = 1'b1;
    in_desc = d;
    while (!taken && n < max_wait) begin
      #1;
      if (in_ready === 1'b1) begin
        @(posedge clk_sys);
        taken = 1'b1;
      end
      @(negedge clk_sys);
      n++;
    end
    // Released lines show a changed value, not the stale header
    in_valid = 1'b0;
    in_desc = ~d;
  endtask : offer
endmodule : tlp_source
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the partition lock and ID-route controller.
// Assumes a 20 MHz core clock and the tlp_source far-side model.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import lock_route_pkg::*;
  localparam logic [5:0] OK = 6'h2A;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic in_valid, in_ready, dec_valid, bus_locked, dsp_locked, up_locked;
  tlp_desc_t in_desc;
  decision_t dec;
  logic [DEF_NPORTS-1:0] acs_uf_en = '0;
  logic [DEF_NPORTS-1:0] posted_to_port = '0;
  logic [DEF_NPORTS-1:0] posted_dsp_to_up = '0;
  logic posted_from_up = 1'b0;
  logic [PORT_W-1:0] locked_port;
  logic took;
  int bad_count = 0;
  int samples_checked = 0;

  always #25 clk_sys = ~clk_sys;

  lock_route_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .in_valid(in_valid),
    .in_ready(in_ready), .in_desc(in_desc), .acs_uf_en(acs_uf_en),
    .posted_to_port(posted_to_port), .posted_dsp_to_up(posted_dsp_to_up),
    .posted_from_up(posted_from_up), .dec_valid(dec_valid), .dec(dec),
    .bus_locked(bus_locked), .dsp_locked(dsp_locked),
    .up_locked(up_locked), .locked_port(locked_port));

  tlp_source u_src (.clk_sys(clk_sys), .in_ready(in_ready),
    .in_valid(in_valid), .in_desc(in_desc));

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : check

  // Flags: route_ok, internal, dev_exists, targets_switch, vc0, inserted
  function automatic tlp_desc_t mk(input tlp_kind_t k, input logic [3:0] s,
                                   input logic [3:0] d, input logic [5:0] f);
    return tlp_desc_t'{k, s, d, f[5], f[4], f[3], f[2], f[1], f[0]};
  endfunction : mk

  task automatic send(input tlp_desc_t d, input verdict_t v,
                      input logic [3:0] eg);
    u_src.offer(d, 20, took);
    check("taken", 8'h01, {7'h00, took});
    check("dec_valid", 8'h01, {7'h00, dec_valid});
    check("verdict", {6'h00, v}, {6'h00, dec.verdict});
    check("kind", {4'h0, d.kind}, {4'h0, dec.kind});
    if (v == V_FWD) begin
      check("egress", {4'h0, eg}, {4'h0, dec.egress});
    end
  endtask : send

  // A held descriptor must not be taken while its condition lasts
  task automatic stall(input tlp_desc_t d);
    u_src.offer(d, 4, took);
    check("stalled", 8'h00, {7'h00, took});
  endtask : stall

  task automatic locks(input logic [2:0] e);
    check("lock_flags", {5'h00, e}, {5'h00, bus_locked, dsp_locked,
      up_locked});
  endtask : locks

  task automatic test_completions();
    send(mk(K_CPL, 4'h5, 4'h5, OK), V_DROP, 4'h0);
    acs_uf_en[5] = 1'b1;
    send(mk(K_CPL, 4'h5, 4'h5, OK), V_FWD, 4'h0);
    send(mk(K_CPL, 4'h2, 4'h6, 6'h0A), V_DROP, 4'h0);
    send(mk(K_CPL, 4'h2, 4'h0, 6'h3A), V_UNEXP, 4'h0);
    acs_uf_en = '0;
    $display("test_completions done");
  endtask : test_completions

  task automatic test_messages();
    send(mk(K_MSG_ID, 4'h6, 4'h6, OK), V_UR, 4'h0);
    acs_uf_en[6] = 1'b1;
    send(mk(K_MSG_ID, 4'h6, 4'h6, OK), V_FWD, 4'h0);
    send(mk(K_MSG_ID, 4'h6, 4'h2, 6'h0A), V_UR, 4'h0);
    send(mk(K_MSG_ID, 4'h0, 4'h2, 6'h22), V_UR, 4'h0);
    send(mk(K_MSG_ID, 4'h4, 4'h2, OK), V_FWD, 4'h2);
    send(mk(K_MSG_T1, 4'h4, 4'h2, 6'h2E), V_UR, 4'h0);
    send(mk(K_MSG_T1, 4'h0, 4'h2, OK), V_UR, 4'h0);
    send(mk(K_MSG_T1_VD, 4'h4, 4'h2, OK), V_DROP, 4'h0);
    send(mk(K_MSG_T1_VD, 4'h0, 4'h2, 6'h2E), V_DROP, 4'h0);
    acs_uf_en = '0;
    $display("test_messages done");
  endtask : test_messages

  task automatic test_lock();
    posted_to_port[3] = 1'b1;
    stall(mk(K_MRDLK, 4'h0, 4'h3, OK));
    posted_to_port[3] = 1'b0;
    send(mk(K_MRDLK, 4'h0, 4'h3, OK), V_FWD, 4'h3);
    locks(3'h2);
    check("locked_port", 8'h03, {4'h0, locked_port});
    stall(mk(K_MWR, 4'h5, 4'h3, OK));
    send(mk(K_MWR, 4'h5, 4'h3, 6'h28), V_FWD, 4'h3);
    send(mk(K_MWR, 4'h5, 4'h7, OK), V_FWD, 4'h7);
    send(mk(K_MRDLK, 4'h0, 4'h4, OK), V_UR, 4'h0);
    posted_dsp_to_up[3] = 1'b1;
    stall(mk(K_CPLD_LK, 4'h3, 4'h0, OK));
    posted_dsp_to_up[3] = 1'b0;
    send(mk(K_CPLD_LK, 4'h3, 4'h0, OK), V_FWD, 4'h0);
    locks(3'h7);
    stall(mk(K_MWR, 4'h5, 4'h0, OK));
    send(mk(K_MSG_ID, 4'h3, 4'h0, 6'h2B), V_FWD, 4'h0);
    send(mk(K_OTHER_P, 4'h3, 4'h3, 6'h2B), V_FWD, 4'h3);
    send(mk(K_MRDLK, 4'h0, 4'h3, OK), V_FWD, 4'h3);
    send(mk(K_CPL_LK, 4'h3, 4'h0, OK), V_FWD, 4'h0);
    locks(3'h7);
    send(mk(K_MWR, 4'h0, 4'h3, OK), V_FWD, 4'h3);
    locks(3'h7);
    send(mk(K_UNLOCK, 4'h5, 4'h3, OK), V_DROP, 4'h0);
    locks(3'h7);
    posted_from_up = 1'b1;
    stall(mk(K_UNLOCK, 4'h0, 4'h3, OK));
    posted_from_up = 1'b0;
    send(mk(K_UNLOCK, 4'h0, 4'h3, OK), V_FWD, 4'h3);
    locks(3'h0);
    send(mk(K_MWR, 4'h5, 4'h3, OK), V_FWD, 4'h3);
    send(mk(K_UNLOCK, 4'h0, 4'h3, OK), V_DROP, 4'h0);
    $display("test_lock done");
  endtask : test_lock

  task automatic test_reset();
    send(mk(K_MRDLK, 4'h0, 4'h3, OK), V_FWD, 4'h3);
    send(mk(K_CPLD_LK, 4'h3, 4'h0, OK), V_FWD, 4'h0);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    locks(3'h0);
    check("locked_port", 8'h00, {4'h0, locked_port});
    check("dec_valid", 8'h00, {7'h00, dec_valid});
    rst = 1'b0;
    send(mk(K_MWR, 4'h5, 4'h3, OK), V_FWD, 4'h3);
    $display("test_reset done");
  endtask : test_reset

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    locks(3'h0);
    test_completions();
    test_messages();
    test_lock();
    test_reset();
    tally_and_finish();
  end

  // Whole run needs about a hundred cycles; a hang is cut at 4000
  initial begin
    #(50 * 4000);
    bad_count++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
